// ==== rtc_counter.sv ====
// loadable up-counter used for each stage of the clock chain
// assumes load and increment come from logic on the same clock
`timescale 1ns/100ps
module rtc_counter #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk_in, // block clock
  input wire logic nrst_in, // power-on reset, active low
  input wire logic load_in, // load has priority over count
  input wire logic [WIDTH-1:0] load_val_in, // value to load
  input wire logic inc_in, // advance by one
  output logic [WIDTH-1:0] count_out, // current count
  output logic at_max_out // count is all ones
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // all ones rolls over to zero on the next increment
  always_comb begin
    count_d = count_q;
    if (load_in) begin
      count_d = load_val_in;
    end else if (inc_in) begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign count_out = count_q;
  assign at_max_out = &count_q;

endmodule // rtc_counter

// ==== rtc_cpu_model.sv ====
// processor-side master of the internal peripheral bus
// assumes strobes taken at a rising edge, read data one edge later
`timescale 1ns/100ps
module rtc_cpu_model (
  input wire logic sys_clk_in, // block clock
  output logic [15:0] bus_addr_out, // word address
  output logic bus_wr_out, // write strobe
  output logic bus_rd_out, // read strobe
  output logic [15:0] bus_wdata_out, // write data
  input wire logic [15:0] bus_rdata_in // read data
);
  initial begin
    bus_addr_out = 16'h0000;
    bus_wr_out = 1'b0;
    bus_rd_out = 1'b0;
    bus_wdata_out = 16'h0000;
  end
  // released data is inverted so a stale value cannot pass for fresh
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    bus_addr_out <= a;
    bus_wdata_out <= d;
    bus_wr_out <= 1'b1;
    @(posedge sys_clk_in);
    bus_wr_out <= 1'b0;
    bus_wdata_out <= ~d;
  endtask
  task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    bus_addr_out <= a;
    bus_rd_out <= 1'b1;
    @(posedge sys_clk_in);
    bus_rd_out <= 1'b0;
    #1;
    d = bus_rdata_in;
  endtask
endmodule // rtc_cpu_model

// ==== rtc_pkg.sv ====
// constants for the real-time clock block: register map, fields, widths
// assumes a 16-bit internal peripheral bus with word addresses
package rtc_pkg;

  // bus shape
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // register offsets on the internal peripheral bus
  localparam logic [15:0] OFF_CTRL = 16'hec00;
  localparam logic [15:0] OFF_PRESCALER_LOW = 16'hec06;
  localparam logic [15:0] OFF_PRESCALER_HIGH = 16'hec08;
  localparam logic [15:0] OFF_DIVIDER_LOW = 16'hec0a;
  localparam logic [15:0] OFF_DIVIDER_HIGH = 16'hec0c;
  localparam logic [15:0] OFF_TIME_COUNTER_LOW = 16'hec0e;
  localparam logic [15:0] OFF_TIME_COUNTER_HIGH = 16'hec10;
  localparam logic [15:0] OFF_ALARM_LOW = 16'hec12;
  localparam logic [15:0] OFF_ALARM_HIGH = 16'hec14;

  // control register fields
  localparam int BIT_SWITCH_OFF = 7;
  localparam int BIT_ALARM_ENABLE = 3;
  localparam int BIT_ALARM_FLAG = 2;
  localparam int BIT_TICK_ENABLE = 1;
  localparam int BIT_TICK_FLAG = 0;

  // counter chain widths: 6 + 20 + 32 = 58
  localparam int PREDIV_W = 6;
  localparam int DIV_W = 20;
  localparam int DIV_HIGH_W = 4;
  localparam int DIV_LOW_W = 16;
  localparam int TIME_W = 32;
  localparam int HALF_W = 16;
  localparam int TIMEBASE_W = PREDIV_W + DIV_W + TIME_W;

  // fast interrupt lines
  localparam int FIRQ_W = 4;
  localparam int FIRQ_TICK = 2;
  localparam int FIRQ_ALARM = 3;

  // reset values of the power-on reset
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [19:0] PRESCALER_RESET = 20'h00000;
  localparam logic [31:0] TIME_RESET = 32'h00000000;
  localparam logic [31:0] ALARM_RESET = 32'h00000000;
  localparam logic [15:0] RDATA_RESET = 16'h0000;

endpackage

// ==== rtc_prescaler_counter_alarm.sv ====
// real-time clock: fixed predivider, reloadable divider, time counter
// and alarm compare, with registers on the internal peripheral bus
// assumes bus strobes and power-down status come from same-clock logic
`timescale 1ns/100ps
module rtc_prescaler_counter_alarm (
  input wire logic sys_clk_in, // processor clock, 10 MHz
  input wire logic nrst_in, // power-on reset, active low
  input wire logic [15:0] bus_addr_in, // bus word address
  input wire logic bus_wr_in, // write strobe, one cycle
  input wire logic bus_rd_in, // read strobe, one cycle
  input wire logic [15:0] bus_wdata_in, // write data
  output logic [15:0] bus_rdata_out, // read data, next cycle
  input wire logic powerdown_in, // chip is in power down
  input wire logic powerdown_config_bit_in, // wakeup allowed
  output logic tick_request_out, // tick flag
  output logic alarm_request_out, // alarm flag
  output logic [3:0] fast_irq_out, // fast external interrupt lines
  output logic wakeup_out, // leave power down
  output logic osc_stop_out, // stop oscillator
  output logic [57:0] time_base_out // full chained count
);

  // control register state
  logic switch_off_q;
  logic switch_off_d;
  logic alarm_enable_q;
  logic alarm_enable_d;
  logic alarm_flag_q;
  logic alarm_flag_d;
  logic tick_enable_q;
  logic tick_enable_d;
  logic tick_flag_q;
  logic tick_flag_d;

  // prescaler value, alarm value
  logic [19:0] prescaler_value_q;
  logic [19:0] prescaler_value_d;
  logic [31:0] alarm_q;
  logic [31:0] alarm_d;

  // output flops, and the flop holding the last alarm match
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [3:0] firq_q;
  logic [3:0] firq_d;
  logic wakeup_q;
  logic wakeup_d;
  logic osc_stop_q;
  logic osc_stop_d;
  logic match_q;

  // counter chain
  logic run;
  logic [5:0] prediv_count;
  logic prediv_max;
  logic prediv_tick;
  logic [19:0] divider_count;
  logic divider_max;
  logic basic_tick;
  logic divider_load;
  logic [19:0] divider_load_val;
  logic [31:0] time_count;
  logic time_load;
  logic [31:0] time_load_val;

  // address decode
  logic sel_ctrl;
  logic sel_pre_low;
  logic sel_pre_high;
  logic sel_div_low;
  logic sel_div_high;
  logic sel_tc_low;
  logic sel_tc_high;
  logic sel_al_low;
  logic sel_al_high;
  logic wr_ctrl;
  logic wr_pre_low;
  logic wr_pre_high;
  logic wr_tc_low;
  logic wr_tc_high;
  logic wr_al_low;
  logic wr_al_high;
  logic unlocked;

  assign sel_ctrl = bus_addr_in == rtc_pkg::OFF_CTRL;
  assign sel_pre_low = bus_addr_in == rtc_pkg::OFF_PRESCALER_LOW;
  assign sel_pre_high = bus_addr_in == rtc_pkg::OFF_PRESCALER_HIGH;
  assign sel_div_low = bus_addr_in == rtc_pkg::OFF_DIVIDER_LOW;
  assign sel_div_high = bus_addr_in == rtc_pkg::OFF_DIVIDER_HIGH;
  assign sel_tc_low = bus_addr_in == rtc_pkg::OFF_TIME_COUNTER_LOW;
  assign sel_tc_high = bus_addr_in == rtc_pkg::OFF_TIME_COUNTER_HIGH;
  assign sel_al_low = bus_addr_in == rtc_pkg::OFF_ALARM_LOW;
  assign sel_al_high = bus_addr_in == rtc_pkg::OFF_ALARM_HIGH;

  // writes to the running chain would tear the count, so they are
  // dropped silently unless the block is switched off
  assign unlocked = switch_off_q;
  assign wr_ctrl = bus_wr_in && sel_ctrl;
  assign wr_pre_low = bus_wr_in && sel_pre_low && unlocked;
  assign wr_pre_high = bus_wr_in && sel_pre_high && unlocked;
  assign wr_tc_low = bus_wr_in && sel_tc_low && unlocked;
  assign wr_tc_high = bus_wr_in && sel_tc_high && unlocked;
  assign wr_al_low = bus_wr_in && sel_al_low;
  assign wr_al_high = bus_wr_in && sel_al_high;

  // counter chain
  // runs on the processor clock in every power mode; only the
  // switch-off bit halts it
  assign run = !switch_off_q;

  rtc_counter #(
    .WIDTH(rtc_pkg::PREDIV_W)
  ) u_prediv (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .load_in(1'b0),
    .load_val_in('0),
    .inc_in(run),
    .count_out(prediv_count),
    .at_max_out(prediv_max)
  );

  // one pulse every 64 clocks
  assign prediv_tick = run && prediv_max;

  // divider counts up; all ones at a predivider pulse ends the period and reloads
  assign basic_tick = prediv_tick && divider_max;
  // a prescaler write also reaches the divider straight away
  assign divider_load = basic_tick || wr_pre_low || wr_pre_high;
  assign divider_load_val = prescaler_value_d;

  rtc_counter #(
    .WIDTH(rtc_pkg::DIV_W)
  ) u_divider (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .load_in(divider_load),
    .load_val_in(divider_load_val),
    .inc_in(prediv_tick),
    .count_out(divider_count),
    .at_max_out(divider_max)
  );

  // a half write keeps the other half of the running value
  assign time_load = wr_tc_low || wr_tc_high;
  assign time_load_val = wr_tc_high ?
    {bus_wdata_in, time_count[15:0]} :
    {time_count[31:16], bus_wdata_in};

  // natural roll-over of the adder gives all ones to zero
  rtc_counter #(
    .WIDTH(rtc_pkg::TIME_W)
  ) u_time (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .load_in(time_load),
    .load_val_in(time_load_val),
    .inc_in(basic_tick),
    .count_out(time_count),
    .at_max_out()
  );

  // next values of bus-written registers
  always_comb begin
    prescaler_value_d = prescaler_value_q;
    if (wr_pre_low) begin
      prescaler_value_d[15:0] = bus_wdata_in;
    end
    if (wr_pre_high) begin
      prescaler_value_d[19:16] = bus_wdata_in[3:0];
    end
  end

  always_comb begin
    alarm_d = alarm_q;
    if (wr_al_low) begin
      alarm_d[15:0] = bus_wdata_in;
    end
    if (wr_al_high) begin
      alarm_d[31:16] = bus_wdata_in;
    end
  end

  // alarm compare and request flags
  logic match_now;
  logic match_event;
  logic tick_set;
  logic alarm_set;

  assign match_now = time_count == alarm_q;
  // only a fresh equality counts, so a held match fires once
  assign match_event = match_now && !match_q;
  assign tick_set = basic_tick && tick_enable_q;
  assign alarm_set = match_event && alarm_enable_q;

  always_comb begin
    switch_off_d = switch_off_q;
    alarm_enable_d = alarm_enable_q;
    tick_enable_d = tick_enable_q;
    alarm_flag_d = alarm_flag_q;
    tick_flag_d = tick_flag_q;
    if (wr_ctrl) begin
      switch_off_d = bus_wdata_in[rtc_pkg::BIT_SWITCH_OFF];
      alarm_enable_d = bus_wdata_in[rtc_pkg::BIT_ALARM_ENABLE];
      tick_enable_d = bus_wdata_in[rtc_pkg::BIT_TICK_ENABLE];
      alarm_flag_d = bus_wdata_in[rtc_pkg::BIT_ALARM_FLAG];
      tick_flag_d = bus_wdata_in[rtc_pkg::BIT_TICK_FLAG];
    end
    // a hardware event in the clearing cycle is kept
    if (alarm_set) begin
      alarm_flag_d = 1'b1;
    end
    if (tick_set) begin
      tick_flag_d = 1'b1;
    end
  end

  // read mux
  logic [15:0] ctrl_view;
  logic [15:0] read_word;

  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[rtc_pkg::BIT_SWITCH_OFF] = switch_off_q;
    ctrl_view[rtc_pkg::BIT_ALARM_ENABLE] = alarm_enable_q;
    ctrl_view[rtc_pkg::BIT_ALARM_FLAG] = alarm_flag_q;
    ctrl_view[rtc_pkg::BIT_TICK_ENABLE] = tick_enable_q;
    ctrl_view[rtc_pkg::BIT_TICK_FLAG] = tick_flag_q;
  end

  // unmapped addresses read as zero
  always_comb begin
    read_word = 16'h0000;
    case (1'b1)
      sel_ctrl: begin
        read_word = ctrl_view;
      end
      sel_pre_low: begin
        read_word = prescaler_value_q[15:0];
      end
      sel_pre_high: begin
        read_word = {12'h000, prescaler_value_q[19:16]};
      end
      sel_div_low: begin
        read_word = divider_count[15:0];
      end
      sel_div_high: begin
        read_word = {12'h000, divider_count[19:16]};
      end
      sel_tc_low: begin
        read_word = time_count[15:0];
      end
      sel_tc_high: begin
        read_word = time_count[31:16];
      end
      sel_al_low: begin
        read_word = alarm_q[15:0];
      end
      sel_al_high: begin
        read_word = alarm_q[31:16];
      end
      default: begin
        read_word = 16'h0000;
      end
    endcase
  end

  // data holds until the next read strobe
  assign rdata_d = bus_rd_in ? read_word : rdata_q;

  // interrupt lines and power control
  always_comb begin
    firq_d = 4'h0;
    firq_d[rtc_pkg::FIRQ_TICK] = tick_flag_d;
    firq_d[rtc_pkg::FIRQ_ALARM] = alarm_flag_d;
  end

  // either request pulls the chip out, but only if configured to
  assign wakeup_d = powerdown_in && powerdown_config_bit_in &&
    (tick_flag_d || alarm_flag_d);
  assign osc_stop_d = powerdown_in && switch_off_d;

  // flops; nrst_in is the block's own power-on reset, there is no
  // system reset input at all
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      switch_off_q <= rtc_pkg::CTRL_RESET[rtc_pkg::BIT_SWITCH_OFF];
      alarm_enable_q <= rtc_pkg::CTRL_RESET[rtc_pkg::BIT_ALARM_ENABLE];
      alarm_flag_q <= rtc_pkg::CTRL_RESET[rtc_pkg::BIT_ALARM_FLAG];
      tick_enable_q <= rtc_pkg::CTRL_RESET[rtc_pkg::BIT_TICK_ENABLE];
      tick_flag_q <= rtc_pkg::CTRL_RESET[rtc_pkg::BIT_TICK_FLAG];
    end else begin
      switch_off_q <= switch_off_d;
      alarm_enable_q <= alarm_enable_d;
      alarm_flag_q <= alarm_flag_d;
      tick_enable_q <= tick_enable_d;
      tick_flag_q <= tick_flag_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prescaler_value_q <= rtc_pkg::PRESCALER_RESET;
      alarm_q <= rtc_pkg::ALARM_RESET;
    end else begin
      prescaler_value_q <= prescaler_value_d;
      alarm_q <= alarm_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      match_q <= 1'b0;
      rdata_q <= rtc_pkg::RDATA_RESET;
      firq_q <= 4'h0;
      wakeup_q <= 1'b0;
      osc_stop_q <= 1'b0;
    end else begin
      match_q <= match_now;
      rdata_q <= rdata_d;
      firq_q <= firq_d;
      wakeup_q <= wakeup_d;
      osc_stop_q <= osc_stop_d;
    end
  end

  // outputs, all from flops
  assign bus_rdata_out = rdata_q;
  assign tick_request_out = tick_flag_q;
  assign alarm_request_out = alarm_flag_q;
  assign fast_irq_out = firq_q;
  assign wakeup_out = wakeup_q;
  assign osc_stop_out = osc_stop_q;
  // counter flops concatenated: time, divider, predivider
  assign time_base_out = {time_count, divider_count, prediv_count};

endmodule // rtc_prescaler_counter_alarm

// ==== rtc_prescaler_counter_alarm_tb.sv ====
// self-checking bench for the real-time clock block
// assumes the processor model drives the bus and the checker is bound
`timescale 1ns/100ps
module rtc_prescaler_counter_alarm_tb;
  typedef struct {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } row_t;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [15:0] bus_addr_in, bus_wdata_in, bus_rdata_out, rd;
  logic bus_wr_in, bus_rd_in, tick_request_out, alarm_request_out;
  logic wakeup_out, osc_stop_out;
  logic powerdown_in = 1'b0;
  logic powerdown_config_bit_in = 1'b0;
  logic [3:0] fast_irq_out;
  logic [57:0] time_base_out;
  int error_cnt = 0;
  int total_checks = 0;
  int n;
  row_t rows [9];
  always #50 sys_clk_in = ~sys_clk_in;
  rtc_cpu_model i_rtc_cpu_model (.sys_clk_in, .bus_addr_out(bus_addr_in),
    .bus_wr_out(bus_wr_in), .bus_rd_out(bus_rd_in),
    .bus_wdata_out(bus_wdata_in), .bus_rdata_in(bus_rdata_out));
  rtc_prescaler_counter_alarm i_rtc_prescaler_counter_alarm (.sys_clk_in,
    .nrst_in, .bus_addr_in, .bus_wr_in, .bus_rd_in, .bus_wdata_in,
    .bus_rdata_out, .powerdown_in, .powerdown_config_bit_in,
    .tick_request_out, .alarm_request_out, .fast_irq_out, .wakeup_out,
    .osc_stop_out, .time_base_out);
  task automatic give_verdict();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_val(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for the next change of the time counter field
  task automatic wait_time(output int cnt);
    logic [31:0] t0;
    t0 = time_base_out[57:26];
    cnt = 0;
    while (time_base_out[57:26] === t0) begin
      @(posedge sys_clk_in);
      #1;
      cnt++;
      if (cnt > 400) begin
        error_cnt++;
        give_verdict();
      end
    end
  endtask
  initial begin
    // prescaler ffffe gives a tick every 64 * 2 clocks
    rows = '{
      '{rtc_pkg::OFF_PRESCALER_LOW, 16'hfffe, 16'hfffe},
      '{rtc_pkg::OFF_PRESCALER_HIGH, 16'h00ff, 16'h000f},
      '{rtc_pkg::OFF_DIVIDER_LOW, 16'h1234, 16'hfffe},
      '{rtc_pkg::OFF_DIVIDER_HIGH, 16'h0000, 16'h000f},
      '{rtc_pkg::OFF_TIME_COUNTER_LOW, 16'hffff, 16'hffff},
      '{rtc_pkg::OFF_TIME_COUNTER_HIGH, 16'hffff, 16'hffff},
      '{rtc_pkg::OFF_ALARM_LOW, 16'h0001, 16'h0001},
      '{rtc_pkg::OFF_ALARM_HIGH, 16'h0000, 16'h0000},
      '{16'hec02, 16'h5a5a, 16'h0000}
    };
    repeat (5) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].addr != rtc_pkg::OFF_DIVIDER_LOW &&
        rows[i].addr != rtc_pkg::OFF_DIVIDER_HIGH) begin
        i_rtc_cpu_model.rd_reg(rows[i].addr, rd);
        chk_val("reset value", 32'h0, {16'h0, rd});
      end
    end
    i_rtc_cpu_model.wr_reg(rtc_pkg::OFF_CTRL, 16'h0080);
    foreach (rows[i]) begin
      i_rtc_cpu_model.wr_reg(rows[i].addr, rows[i].wdata);
      i_rtc_cpu_model.rd_reg(rows[i].addr, rd);
      chk_val("readback", {16'h0, rows[i].exp}, {16'h0, rd});
    end
    chk_val("base divider", 32'hffffe, {12'h0, time_base_out[25:6]});
    chk_val("base time", 32'hffffffff, time_base_out[57:26]);
    i_rtc_cpu_model.wr_reg(rtc_pkg::OFF_CTRL, 16'h000a);
    i_rtc_cpu_model.rd_reg(rtc_pkg::OFF_CTRL, rd);
    chk_val("control", 32'h000a, {16'h0, rd});
    wait_time(n);
    chk_val("wrapped time", 32'h0, time_base_out[57:26]);
    chk_val("irq lines", 32'h4, {28'h0, fast_irq_out});
    wait_time(n);
    chk_val("tick period", 32'h80, n);
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk_val("alarm lines", 32'hc, {28'h0, fast_irq_out});
    i_rtc_cpu_model.wr_reg(rtc_pkg::OFF_TIME_COUNTER_LOW, 16'h5555);
    i_rtc_cpu_model.rd_reg(rtc_pkg::OFF_TIME_COUNTER_LOW, rd);
    chk_val("locked time", 32'h1, {16'h0, rd});
    i_rtc_cpu_model.wr_reg(rtc_pkg::OFF_CTRL, 16'h0008);
    powerdown_in <= 1'b1;
    powerdown_config_bit_in <= 1'b1;
    wait_time(n);
    chk_val("power down time", 32'h2, time_base_out[57:26]);
    chk_val("tick off", 32'h0, {31'h0, tick_request_out});
    chk_val("idle wakeup", 32'h0, {31'h0, wakeup_out});
    chk_val("osc runs", 32'h0, {31'h0, osc_stop_out});
    i_rtc_cpu_model.wr_reg(rtc_pkg::OFF_CTRL, 16'h000a);
    wait_time(n);
    @(posedge sys_clk_in);
    #1;
    chk_val("wakeup", 32'h1, {31'h0, wakeup_out});
    i_rtc_cpu_model.wr_reg(rtc_pkg::OFF_CTRL, 16'h0080);
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk_val("osc stop", 32'h1, {31'h0, osc_stop_out});
    give_verdict();
  end
endmodule // rtc_prescaler_counter_alarm_tb

// ==== rtc_sva.sv ====
// concurrent checks on the real-time clock block's ports
// assumes it is bound into the top module, one clock domain
`timescale 1ns/100ps
module rtc_sva (
  input wire logic sys_clk_in, // block clock
  input wire logic nrst_in, // power-on reset
  input wire logic [15:0] bus_addr_in, // bus address
  input wire logic bus_wr_in, // write strobe
  input wire logic bus_rd_in, // read strobe
  input wire logic [15:0] bus_rdata_out, // read data
  input wire logic powerdown_in, // power down
  input wire logic powerdown_config_bit_in, // wakeup allowed
  input wire logic tick_request_out, // tick flag
  input wire logic alarm_request_out, // alarm flag
  input wire logic [3:0] fast_irq_out, // fast lines
  input wire logic wakeup_out, // wakeup
  input wire logic osc_stop_out, // oscillator stop
  input wire logic [57:0] time_base_out // chained count
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic [31:0] tm = time_base_out[57:26];
  wire logic [19:0] dv = time_base_out[25:6];
  wire logic [5:0] pd = time_base_out[5:0];
  // the divider step may land one edge late if the pulse is registered
  sequence s_prediv_wrap;
    pd == 6'h3f ##1 pd == 6'h00 ##1 1'b1;
  endsequence
  AST_PREDIV: assert property (s_prediv_wrap |-> dv != $past(dv, 2))
    else $error("divider did not step on predivider wrap");
  AST_DIV_HOLD: assert property (pd inside {[6'h01:6'h3e]} &&
    !bus_wr_in |=> $stable(dv))
    else $error("divider moved between predivider pulses");
  AST_TIME_STEP: assert property (!$past(bus_wr_in) &&
    tm != $past(tm) |-> tm == $past(tm) + 32'h1)
    else $error("time counter moved by other than one");
  AST_TICK_SET: assert property ($rose(tick_request_out) |->
    tm != $past(tm) || $past(bus_wr_in))
    else $error("tick flag rose without a tick");
  AST_FLAG_HOLD: assert property (tick_request_out &&
    !bus_wr_in |=> tick_request_out)
    else $error("tick flag dropped without a write");
  AST_ALARM_HOLD: assert property (alarm_request_out &&
    !bus_wr_in |=> alarm_request_out)
    else $error("alarm flag dropped without a write");
  AST_FIRQ: assert property (fast_irq_out ==
    {alarm_request_out, tick_request_out, 2'b00})
    else $error("fast interrupt lines do not follow flags");
  AST_WAKE: assert property ($rose(wakeup_out) |->
    $past(powerdown_in && powerdown_config_bit_in))
    else $error("wakeup without power down and config");
  AST_NO_WAKE: assert property (!powerdown_config_bit_in |=>
    !wakeup_out)
    else $error("wakeup while config bit clear");
  AST_OSC: assert property (osc_stop_out |-> $past(powerdown_in))
    else $error("oscillator stopped outside power down");
  AST_HIGH_ZERO: assert property (bus_rd_in &&
    (bus_addr_in == rtc_pkg::OFF_PRESCALER_HIGH ||
    bus_addr_in == rtc_pkg::OFF_DIVIDER_HIGH) |=>
    bus_rdata_out[15:4] == 12'h000)
    else $error("unused upper bits not zero");
  AST_RD_HOLD: assert property (!bus_rd_in |=>
    $stable(bus_rdata_out))
    else $error("read data changed without a read");
endmodule // rtc_sva

bind rtc_prescaler_counter_alarm rtc_sva i_rtc_sva (.sys_clk_in, .nrst_in,
  .bus_addr_in, .bus_wr_in, .bus_rd_in, .bus_rdata_out, .powerdown_in,
  .powerdown_config_bit_in, .tick_request_out, .alarm_request_out,
  .fast_irq_out, .wakeup_out, .osc_stop_out, .time_base_out);
